// ---- core/tac_consts.vh ----
`ifndef TAC_CONSTS_VH
`define TAC_CONSTS_VH
// register pointer addresses
`define TAC_PTR_CONFIG 8'h01
`define TAC_PTR_UPPER 8'h02
// configuration field positions
`define TAC_CFG_MODE 0
`define TAC_CFG_POL 1
`define TAC_CFG_CRIT 2
`define TAC_CFG_EN 3
`define TAC_CFG_STS 4
`define TAC_CFG_REL 5
`define TAC_CFG_WLOCK 6
`define TAC_CFG_CLOCK 7
`define TAC_CFG_SHDN 8
`define TAC_CFG_HYS_LO 9
`define TAC_CFG_HYS_HI 10
// upper limit value field
`define TAC_LIM_HI 12
`define TAC_LIM_LO 2
// reset values
`define TAC_LIM_RESET 11'h000
`define TAC_HYS_RESET 2'h0
// hysteresis amounts in 0.125 degree steps
`define TAC_HYS_NONE 13'h0000
`define TAC_HYS_1P5 13'h000c
`define TAC_HYS_3P0 13'h0018
`define TAC_HYS_6P0 13'h0030
`endif

// ---- core/tac_alarm.v ----
// Operation
// RULE1: status bit 4 shows pin asserted by trip
// RULE2: shutdown clears status, resumes on exit
// RULE3: bit 3 enables alarm pin, default off
// RULE4: either lock freezes enable, polarity, mode
// RULE5: bit 2 restricts pin to critical alarm
// RULE6: critical-only bit frozen by window lock only
// RULE7: bit 1 polarity, default active low pulldown
// RULE8: bit 0 mode, comparator default, interrupt
// RULE9: host sets bit 2 before bit 3
// RULE10: limits reset to zero degrees
// RULE11: upper limit 11-bit two's complement, bits 12:2
// RULE12: trip above limit, clear below minus hysteresis; the code also clears at exactly limit minus hysteresis
// RULE13: window lock makes upper limit read-only
// RULE14: upper limit reserved bits read zero
// RULE15: upper limit 16-bit at pointer 2
// RULE16: release strobe clears interrupt-mode pin
// RULE17: locks clear only by power-on reset
// RULE18: shutdown stops alarms, pin undriven
// RULE19: hysteresis select falling only, four steps
// RULE20: comparator follows trip, interrupt latches
`timescale 1ns/10ps
`include "tac_consts.vh"

module tac_alarm (
    // clock and reset
    input wire sys_clk,
    input wire rst_b,
    // register access from the serial protocol engine
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    // temperature word, bits 12:1 two's complement, 0.125 degree steps
    input wire [15:0] temp_word,
    // lower and critical trips from their own comparators
    input wire lower_trip,
    input wire crit_trip,
    // upper trip status for the temperature register
    output reg upper_trip,
    // alarm pin, three signals
    input wire event_pin_in,
    output reg event_pin_out,
    output reg event_pin_oe,
    // conversion gate
    output reg conv_enable
);

    // configuration state
    reg event_mode_select; // 0 comparator, 1 interrupt
    reg event_polarity_select; // 0 active low
    reg critical_only_select; // 1 critical alarm only
    reg event_output_enable; // pin may assert
    reg event_pin_state_flag; // pin asserted by a trip
    reg window_limit_lock; // set-only
    reg critical_limit_lock; // set-only
    reg sensor_shutdown; // sensor off
    reg [1:0] hysteresis_select; // falling hysteresis
    reg [10:0] upper_limit_value; // limit bits 12:2
    // interrupt-mode latch and edge memory
    reg event_latch; // held pin request in interrupt mode
    reg trip_prev; // qualified trip of the last edge
    // the pin read-back is left unused: the driven level is known here,
    // and a slow external pull-up would only add a false late edge

    // decoded strobes
    // pointer decode is full eight bits, so aliases never reach a register
    wire cfg_wr = reg_wr && (reg_addr == `TAC_PTR_CONFIG);
    wire lim_wr = reg_wr && (reg_addr == `TAC_PTR_UPPER);
    wire any_lock = window_limit_lock | critical_limit_lock;
    // the release bit is never stored, so it acts for one edge only
    wire release_req = cfg_wr && reg_wdata[`TAC_CFG_REL];

    // 13-bit signed compare keeps limit minus hysteresis from wrapping
    // temperature bits 12:1, sign-extended by one bit
    wire [12:0] temp_ext = {temp_word[12], temp_word[12:1]};
    // limit bits 12:2 padded with a zero to line up with the temperature
    wire [12:0] lim_ext = {upper_limit_value[10], upper_limit_value, 1'b0};
    reg [12:0] hys_amt; // hysteresis in 0.125 degree steps
    // hysteresis amount from the two-bit select
    always @* begin
        case (hysteresis_select) // RULE19
            2'h1: hys_amt = `TAC_HYS_1P5;
            2'h2: hys_amt = `TAC_HYS_3P0;
            2'h3: hys_amt = `TAC_HYS_6P0;
            default: hys_amt = `TAC_HYS_NONE;
        endcase
    end
    wire [12:0] lim_fall = lim_ext - hys_amt;
    wire above_lim = $signed(temp_ext) > $signed(lim_ext);
    wire at_or_below_fall = $signed(temp_ext) <= $signed(lim_fall);

    // upper trip with hysteresis; frozen while no conversions run
    // the clear point uses <=, so a temperature sitting exactly on
    // limit minus hysteresis already clears the trip
    wire next_upper_trip = sensor_shutdown ? upper_trip :
        (above_lim ? 1'b1 : (at_or_below_fall ? 1'b0 : upper_trip)); // RULE12

    // qualified trip: critical-only hides upper and lower alarms
    wire trip_any = critical_only_select ? crit_trip :
        (crit_trip | next_upper_trip | lower_trip); // RULE5
    // rising edge of the qualified trip; sets the latch in either mode, but the latch drives the pin only in interrupt mode
    wire trip_new = trip_any & ~trip_prev;

    // interrupt latch: new trip sets, release clears, set wins
    wire next_event_latch = (sensor_shutdown | ~event_output_enable) ? 1'b0 :
        (trip_new ? 1'b1 :
        ((release_req && event_mode_select) ? 1'b0 : event_latch)); // RULE16

    // pin asserted level: follow trip or the latch
    wire pin_active = event_output_enable && !sensor_shutdown &&
        (event_mode_select ? next_event_latch : trip_any); // RULE20 RULE3

    // configuration and limit registers
    // a write that sets a lock still lands its other fields: the lock
    // only guards writes that come after it
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            event_mode_select <= 1'b0; // RULE8
            event_polarity_select <= 1'b0; // RULE7
            critical_only_select <= 1'b0;
            event_output_enable <= 1'b0; // RULE3
            window_limit_lock <= 1'b0;
            critical_limit_lock <= 1'b0;
            sensor_shutdown <= 1'b0;
            // hysteresis off at power-on, limit at zero degrees
            hysteresis_select <= `TAC_HYS_RESET;
            upper_limit_value <= `TAC_LIM_RESET; // RULE10 RULE15
        end else begin
            if (cfg_wr) begin
                // these follow either lock
                if (!any_lock) begin
                    event_mode_select <= reg_wdata[`TAC_CFG_MODE]; // RULE4
                    event_polarity_select <= reg_wdata[`TAC_CFG_POL];
                    event_output_enable <= reg_wdata[`TAC_CFG_EN];
                    sensor_shutdown <= reg_wdata[`TAC_CFG_SHDN];
                    hysteresis_select <=
                        reg_wdata[`TAC_CFG_HYS_HI:`TAC_CFG_HYS_LO];
                end
                // only the window lock guards this bit
                if (!window_limit_lock) begin
                    critical_only_select <= reg_wdata[`TAC_CFG_CRIT]; // RULE6
                end
                // locks only ever set; a zero write is ignored, and only
                // the power-on reset branch above returns them to zero
                window_limit_lock <= window_limit_lock |
                    reg_wdata[`TAC_CFG_WLOCK]; // RULE17
                critical_limit_lock <= critical_limit_lock |
                    reg_wdata[`TAC_CFG_CLOCK];
            end
            // reserved bits of the word are never stored; the critical
            // lock alone leaves the upper limit writable
            if (lim_wr && !window_limit_lock) begin
                upper_limit_value <=
                    reg_wdata[`TAC_LIM_HI:`TAC_LIM_LO]; // RULE13 RULE11
            end
        end
    end

    // alarm state and pin drive
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            upper_trip <= 1'b0;
            trip_prev <= 1'b0;
            event_latch <= 1'b0;
            event_pin_state_flag <= 1'b0; // RULE1
            event_pin_out <= 1'b0;
            event_pin_oe <= 1'b0;
            conv_enable <= 1'b0;
        end else begin
            upper_trip <= next_upper_trip;
            // conversions gated one edge after the shutdown bit changes
            conv_enable <= ~sensor_shutdown; // RULE18
            // edge memory cleared in shutdown so a trip on exit is new
            trip_prev <= sensor_shutdown ? 1'b0 : trip_any;
            event_latch <= next_event_latch;
            // status cleared in shutdown, live again right after; it tracks
            // the asserted level, so it also reads zero while disabled
            event_pin_state_flag <= pin_active; // RULE2 RULE1
            if (sensor_shutdown) begin
                // pin left floating
                event_pin_out <= 1'b0; // RULE18
                event_pin_oe <= 1'b0;
            end else if (event_polarity_select) begin
                // active high drives both levels; a polarity change shows
                // one edge after the write, with no undriven gap
                event_pin_out <= pin_active;
                event_pin_oe <= 1'b1;
            end else begin
                // active low only pulls down; pull-up gives idle level
                event_pin_out <= 1'b0; // RULE7
                event_pin_oe <= pin_active;
            end
        end
    end

    // read data, registered on the read strobe
    // a read shows the state as it stood before the strobe edge, so a
    // write in the same cycle is not yet visible
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `TAC_PTR_CONFIG: begin
                    // release strobe position always reads zero
                    reg_rdata <= {5'h00, hysteresis_select, sensor_shutdown,
                        critical_limit_lock, window_limit_lock, 1'b0,
                        event_pin_state_flag, event_output_enable,
                        critical_only_select, event_polarity_select,
                        event_mode_select}; // RULE16
                end
                `TAC_PTR_UPPER: begin
                    reg_rdata <= {3'h0, upper_limit_value, 2'h0}; // RULE14
                end
                default: begin
                    // pointers outside this block read zero
                    reg_rdata <= 16'h0000;
                end
            endcase
        end
    end

endmodule // tac_alarm

// ---- testbench/tac_alarm_props.sv ----
`timescale 1ns/10ps
`include "tac_consts.vh"

module tac_alarm_props (
    // clock and reset
    input wire sys_clk,
    input wire rst_b,
    // register bus
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_rdata,
    // alarm side
    input wire [15:0] temp_word,
    input wire upper_trip,
    input wire event_pin_out,
    input wire event_pin_oe,
    input wire conv_enable
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // configuration read request
    wire cfg_rd = reg_rd && reg_addr == `TAC_PTR_CONFIG;

    a_lim_reserved: assert property (
        reg_rd && reg_addr == `TAC_PTR_UPPER |=>
        reg_rdata[15:13] == 3'h0 && reg_rdata[1:0] == 2'h0)
        else $error("limit reserved bits not zero");
    a_strobe_zero: assert property (
        cfg_rd |=> reg_rdata[5] == 1'b0)
        else $error("release strobe read back set");
    a_sts_drives: assert property (
        cfg_rd ##1 reg_rdata[4] |-> $past(event_pin_oe))
        else $error("status set with pin idle");
    a_sts_shutdown: assert property (
        cfg_rd && !conv_enable |=> !reg_rdata[4])
        else $error("status set in shutdown");
    a_enable_gates: assert property (
        cfg_rd ##1 reg_rdata[4] |-> reg_rdata[3])
        else $error("status set while output disabled");
    a_low_pulldown: assert property (
        cfg_rd ##1 !reg_rdata[1] |-> !$past(event_pin_out))
        else $error("active low pin driven high");
    a_shdn_undriven: assert property (
        !conv_enable |-> !event_pin_oe)
        else $error("pin driven in shutdown");
    a_trip_cause: assert property (
        $rose(upper_trip) |-> $past(temp_word) != $past(temp_word, 2)
        || $past(reg_wr, 2) || !$past(rst_b, 2))
        else $error("upper trip rose without cause");
endmodule // tac_alarm_props

bind tac_alarm tac_alarm_props props (.sys_clk, .rst_b, .reg_wr, .reg_rd,
    .reg_addr, .reg_rdata, .temp_word, .upper_trip, .event_pin_out,
    .event_pin_oe, .conv_enable);

// ---- testbench/tac_host.sv ----
`timescale 1ns/10ps

module tac_host (
    // bus towards the block
    input wire sys_clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata
);
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    // one write, then an idle edge so reads see settled state
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge sys_clk);
        {reg_wr, reg_wdata} <= {1'b0, ~d};
        @(posedge sys_clk);
    endtask
    // one-cycle read strobe; data lands at the closing edge
    task rd(input logic [7:0] a);
        @(posedge sys_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge sys_clk);
        reg_rd <= 1'b0;
    endtask
endmodule // tac_host

// ---- testbench/thermal_alarm_output_control_tb.sv ----
`timescale 1ns/10ps

module thermal_alarm_output_control_tb;
    logic sys_clk = 0, rst_b = 0, lower_trip = 0, crit_trip = 0;
    logic [15:0] temp_word = 16'h0000, d;
    wire reg_wr, reg_rd, upper_trip, event_pin_out, event_pin_oe, conv_enable;
    wire [7:0] reg_addr;
    wire [15:0] reg_wdata, reg_rdata;
    // pull-up holds the pin high when nobody drives it
    wire event_pin_in = event_pin_oe ? event_pin_out : 1'b1;
    int err_count = 0, cmp_count = 0;
    initial forever #5 sys_clk = ~sys_clk;
    tac_host host (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
    tac_alarm dut (.sys_clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .temp_word, .lower_trip, .crit_trip, .upper_trip,
        .event_pin_in, .event_pin_out, .event_pin_oe, .conv_enable);
    task test_done;
        if (err_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task rd(input logic [7:0] a, input logic [15:0] e, input string n);
        host.rd(a);
        #1 chk(n, e, reg_rdata);
    endtask
    // expected {oe, out} for a given polarity and alarm state
    function automatic logic [15:0] pexp(input logic pol, input logic act);
        return {14'h0000, pol ? {1'b1, act} : {act, 1'b0}};
    endfunction
    task pin(input logic pol, input logic act, input string n);
        repeat (2) @(posedge sys_clk);
        #1 chk(n, pexp(pol, act), {14'h0000, event_pin_oe, event_pin_out});
    endtask
    task t(input logic [15:0] v);
        @(posedge sys_clk);
        temp_word <= v;
    endtask
    // hysteresis walk for one select code, amount a in 0.125 degree steps
    task hyst(input logic [1:0] c, input logic [15:0] a);
        host.wr(8'h01, {5'h00, c, 9'h00a});
        t(16'h0552);
        pin(1, 1, "hys_up");
        t(16'h0552 - (a << 1));
        pin(1, 1, "hys_hold");
        t(16'h0550 - (a << 1));
        pin(1, 0, "hys_fall");
    endtask
    initial begin
        #20000 err_count++;
        test_done;
    end
    initial begin
        void'($urandom(32'h4e6a));
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(8'h02, 16'h0000, "limit");
        rd(8'h01, 16'h0000, "config");
        rd(8'h07, 16'h0000, "unmapped");
        repeat (8) begin
            d = 16'($urandom);
            host.wr(8'h02, d);
            rd(8'h02, d & 16'h1ffc, "limit");
        end
        host.wr(8'h02, 16'h0550);
        host.wr(8'h01, 16'h0208);
        t(16'h0552);
        pin(0, 1, "cmp");
        chk("trip", 16'h0001, {15'h0000, upper_trip});
        t(16'h053a);
        host.wr(8'h01, 16'h0228);
        pin(0, 1, "hys");
        t(16'h0538);
        pin(0, 0, "hys");
        host.wr(8'h01, 16'h0009);
        t(16'h0552);
        pin(0, 1, "int");
        t(16'h0400);
        pin(0, 1, "latch");
        host.wr(8'h01, 16'h0029);
        pin(0, 0, "release");
        host.wr(8'h01, 16'h000a);
        t(16'h0552);
        pin(1, 1, "pol");
        host.wr(8'h01, 16'h0006);
        host.wr(8'h01, 16'h000e);
        pin(1, 0, "crit");
        @(posedge sys_clk) crit_trip <= 1'b1;
        pin(1, 1, "crit");
        @(posedge sys_clk) crit_trip <= 1'b0;
        host.wr(8'h01, 16'h000a);
        t(16'h0400);
        @(posedge sys_clk) lower_trip <= 1'b1;
        pin(1, 1, "lower");
        host.wr(8'h01, 16'h0002);
        pin(1, 0, "off");
        host.wr(8'h01, 16'h010a);
        #1;
        chk("shdn", 16'h0000, {14'h0, event_pin_oe, conv_enable});
        rd(8'h01, 16'h010a, "config");
        host.wr(8'h01, 16'h000a);
        rd(8'h01, 16'h001a, "config");
        @(posedge sys_clk) lower_trip <= 1'b0;
        hyst(2'h1, 16'h000c);
        hyst(2'h2, 16'h0018);
        hyst(2'h3, 16'h0030);
        host.wr(8'h01, 16'h0048);
        host.wr(8'h01, 16'h0007);
        rd(8'h01, 16'h0048, "window_limit_lock");
        host.wr(8'h02, 16'h0100);
        rd(8'h02, 16'h0550, "window_limit_lock");
        @(posedge sys_clk) rst_b <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        host.wr(8'h01, 16'h0088);
        host.wr(8'h01, 16'h0004);
        rd(8'h01, 16'h008c, "critlock");
        host.wr(8'h02, 16'h0100);
        rd(8'h02, 16'h0100, "critlock");
        test_done;
    end
endmodule // thermal_alarm_output_control_tb
